// ---- core/ftc_pkg.sv ----
/*
 * Constants for the fan and thermal configuration register bank:
 * register indices, reset values, field positions and status layout.
 * Assumes a 32-bit AHB-Lite bus; byte address = 4 * register index.
 */
package ftc_pkg;

	////////////////////////////////////////////////////////////////
	// Register indices (byte address is index * 4)
	localparam int          ADDR_LSB        = 2;
	localparam int          IDX_W           = 6;
	localparam logic [5:0]  IDX_CONFIG_ONE  = 6'h00;
	localparam logic [5:0]  IDX_IRQ_STATUS  = 6'h02;
	localparam logic [5:0]  IDX_IRQ_CLEAR   = 6'h03;
	localparam logic [5:0]  IDX_IRQ_ENABLE  = 6'h04;
	localparam logic [5:0]  IDX_EXTRA_RES   = 6'h06;
	localparam logic [5:0]  IDX_FAN_SPEED   = 6'h08;
	localparam logic [5:0]  IDX_LOCAL_TEMP  = 6'h0A;
	localparam logic [5:0]  IDX_REMOTE_TEMP = 6'h0B;
	localparam logic [5:0]  IDX_LOCAL_OFS   = 6'h0D;
	localparam logic [5:0]  IDX_REMOTE_OFS  = 6'h0E;
	localparam logic [5:0]  IDX_TACH_LIMIT  = 6'h10;
	localparam logic [5:0]  IDX_L_HIGH      = 6'h14;
	localparam logic [5:0]  IDX_L_LOW       = 6'h15;
	localparam logic [5:0]  IDX_L_CRIT      = 6'h16;
	localparam logic [5:0]  IDX_R_HIGH      = 6'h18;
	localparam logic [5:0]  IDX_R_LOW       = 6'h19;
	localparam logic [5:0]  IDX_R_CRIT      = 6'h1A;

	////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [7:0]  CFG_RST         = 8'h90;
	localparam logic [7:0]  TACH_LIMIT_RST  = 8'hFF;
	localparam logic [7:0]  L_HIGH_RST      = 8'h3C;
	localparam logic [7:0]  L_LOW_RST       = 8'h00;
	localparam logic [7:0]  L_CRIT_RST      = 8'h46;
	localparam logic [7:0]  R_HIGH_RST      = 8'h50;
	localparam logic [7:0]  R_LOW_RST       = 8'h00;
	localparam logic [7:0]  R_CRIT_RST      = 8'h64;
	localparam logic [7:0]  OFS_RST         = 8'h00;
	localparam logic [7:0]  VALUE_RST       = 8'h00;
	localparam logic [7:0]  IRQ_EN_RST      = 8'h00;

	////////////////////////////////////////////////////////////////
	// First configuration register fields
	localparam int          CFG_MONITOR     = 0;
	localparam int          CFG_INT_EN      = 1;
	localparam int          CFG_SENSE       = 2;
	localparam int          CFG_INVERT      = 3;
	localparam int          CFG_FAULT_EN    = 4;
	localparam int          CFG_SRC_LO      = 5;
	localparam int          CFG_SRC_HI      = 6;
	localparam int          CFG_AUTO        = 7;
	localparam logic [1:0]  SRC_REMOTE      = 2'h0;
	localparam logic [1:0]  SRC_FASTEST     = 2'h3;

	////////////////////////////////////////////////////////////////
	// Interrupt status layout
	localparam int          ST_W            = 8;
	localparam int          ST_TACH         = 0;
	localparam int          ST_L_HIGH       = 1;
	localparam int          ST_L_LOW        = 2;
	localparam int          ST_R_HIGH       = 3;
	localparam int          ST_R_LOW        = 4;
	localparam int          ST_L_CRIT       = 5;
	localparam int          ST_R_CRIT       = 6;
	localparam int          ST_FAULT_PIN    = 7;

	////////////////////////////////////////////////////////////////
	// Fan failure and bus
	localparam int          FAULT_COUNT     = 5;
	localparam logic [2:0]  HSIZE_WORD      = 3'h2;

endpackage

// ---- core/ftc_fault_count.sv ----
/*
 * Consecutive fan tach failure counter driving the fan-failure level.
 * Assumes one valid pulse per accepted tach measurement, same clock.
 */
`timescale 1ns/1ns
module ftc_fault_count #(
	parameter int COUNT = ftc_pkg::FAULT_COUNT
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	// Measurement results
	input  wire logic meas_take,
	input  wire logic tach_fail,
	// Failure level
	output logic      fault
);
	localparam int CW = $clog2(COUNT + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          fault;
	} ftc_fc_st_t;

	ftc_fc_st_t st_r;
	ftc_fc_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (meas_take) begin
			if (tach_fail) begin
				if (st_r.cnt != CW'(COUNT))
					st_nxt.cnt = st_r.cnt + 1'b1;
				if (st_r.cnt >= CW'(COUNT - 1))
					st_nxt.fault = 1'b1;
			end else begin
				st_nxt.cnt = '0;
				st_nxt.fault = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	assign fault = st_r.fault;
endmodule

// ---- core/ftc_irq_status.sv ----
/*
 * Sticky interrupt status with clear mask and enable mask.
 * Assumes set, clear and enable come from logic on the same clock.
 */
`timescale 1ns/1ns
module ftc_irq_status #(
	parameter int W = ftc_pkg::ST_W
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         ce,
	// Events and masks
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	input  wire logic [W-1:0] en,
	// State
	output logic      [W-1:0] status,
	output logic              irq
);
	typedef struct packed {
		logic [W-1:0] status;
		logic         irq;
	} ftc_is_st_t;

	ftc_is_st_t st_r;
	ftc_is_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Set wins over a clear in the same cycle
		st_nxt.status = (st_r.status & ~clr) | set;
		st_nxt.irq = |(st_nxt.status & en);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	assign status = st_r.status;
	assign irq = st_r.irq;
endmodule

// ---- core/ftc_regs_top.sv ----
/*
 * Fan and thermal configuration register bank with AHB-Lite slave,
 * measurement capture, limit checks, interrupt and fan-failure pins.
 * Assumes measurement logic and PWM generator on hclk; zero-wait bus.
 */
// What this block does
// - First configuration register powers up as 0x90.
// - Bit 0 enables temperature and tach measurement; resets to 0.
// - Bit 1 enables the active-low interrupt pin; resets to 0.
// - Bit 2 chooses digital tach or analog speed sensing; resets to 0.
// - Bit 3 inverts fan drive; clear means low at full duty.
// - Bit 4 enables the fan-failure pin; resets to 1.
// - Bits 6:5 pick automatic source: remote temperature or fastest speed.
// - Bit 7 selects automatic control, else software control; resets to 1.
// - Fan speed register holds the tach count; slower fan reads larger.
// - Tach limit resets to FFh; count above limit flags slow fan.
// - Local temperature upper eight bits read-only.
// - Remote temperature upper eight bits read-only.
// - Extra low-order temperature bits read-only.
// - Local high, low, critical limits writable; reset 60, 0, 70.
// - Remote high, low, critical limits writable; reset 80, 0, 100.
// - Local and remote temperature offsets writable.
// - Tach failure raises interrupt and fault flag; status read clears.
// - Fan-failure pin low after five consecutive failures; released on recovery.
`timescale 1ns/1ns
module ftc_regs_top #(
	parameter int FAULT_COUNT = ftc_pkg::FAULT_COUNT
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Measurement results
	input  wire logic        meas_valid,
	input  wire logic [7:0]  meas_tach_count,
	input  wire logic [7:0]  meas_local_temp,
	input  wire logic [7:0]  meas_remote_temp,
	input  wire logic [7:0]  meas_extra_res,
	// Fan drive demand, high while the fan is to be powered
	input  wire logic        pwm_demand,
	// Configuration towards measurement and fan control
	output logic             monitor_en,
	output logic             speed_sense_select,
	output logic             auto_or_software_select,
	output logic      [1:0]  auto_source,
	output logic             sw_target_is_rpm,
	output logic      [7:0]  local_offset,
	output logic      [7:0]  remote_offset,
	// Critical temperature levels
	output logic             local_crit,
	output logic             remote_crit,
	// Pins
	output logic             pwm_out,
	output logic             int_n,
	output logic             fan_fault_n_o,
	output logic             fan_fault_n_oe,
	output logic             irq
);

	////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [7:0]  cfg;
		logic [7:0]  local_ofs;
		logic [7:0]  remote_ofs;
		logic [7:0]  tach_lim;
		logic [7:0]  l_high;
		logic [7:0]  l_low;
		logic [7:0]  l_crit;
		logic [7:0]  r_high;
		logic [7:0]  r_low;
		logic [7:0]  r_crit;
		logic [7:0]  irq_en;
		logic [7:0]  fan_speed;
		logic [7:0]  local_t;
		logic [7:0]  remote_t;
		logic [7:0]  extra_res;
		logic        wr_pend;
		logic [5:0]  wr_idx;
		logic [31:0] hrdata;
		logic        hready;
		logic        hresp;
		logic        meas_take;
		logic        tach_fail;
		logic [7:0]  set_ev;
		logic [7:0]  clr_mask;
		logic        fault_prev;
		logic        local_crit;
		logic        remote_crit;
		logic        pwm_out;
		logic        int_n;
		logic        fault_o;
		logic        fault_oe;
		logic        rpm_target;
	} ftc_st_t;

	ftc_st_t          st_r;
	ftc_st_t          st_nxt;
	logic [7:0]       irq_status;
	logic             irq_level;
	logic             fan_fault;

	////////////////////////////////////////////////////////////////
	// Helpers

	// Temperatures are two's complement
	function automatic logic temp_above(input logic [7:0] v, input logic [7:0] lim);
		temp_above = $signed(v) > $signed(lim);
	endfunction

	function automatic logic tach_over(input logic [7:0] count, input logic [7:0] lim);
		tach_over = count > lim;
	endfunction

	function automatic logic [7:0] read_reg(input ftc_st_t s, input logic [5:0] idx,
		input logic [7:0] status);
		read_reg = 8'h00;
		unique case (idx)
			ftc_pkg::IDX_CONFIG_ONE:  read_reg = s.cfg;
			ftc_pkg::IDX_IRQ_STATUS:  read_reg = status;
			ftc_pkg::IDX_IRQ_ENABLE:  read_reg = s.irq_en;
			ftc_pkg::IDX_EXTRA_RES:   read_reg = s.extra_res;
			ftc_pkg::IDX_FAN_SPEED:   read_reg = s.fan_speed;
			ftc_pkg::IDX_LOCAL_TEMP:  read_reg = s.local_t;
			ftc_pkg::IDX_REMOTE_TEMP: read_reg = s.remote_t;
			ftc_pkg::IDX_LOCAL_OFS:   read_reg = s.local_ofs;
			ftc_pkg::IDX_REMOTE_OFS:  read_reg = s.remote_ofs;
			ftc_pkg::IDX_TACH_LIMIT:  read_reg = s.tach_lim;
			ftc_pkg::IDX_L_HIGH:      read_reg = s.l_high;
			ftc_pkg::IDX_L_LOW:       read_reg = s.l_low;
			ftc_pkg::IDX_L_CRIT:      read_reg = s.l_crit;
			ftc_pkg::IDX_R_HIGH:      read_reg = s.r_high;
			ftc_pkg::IDX_R_LOW:       read_reg = s.r_low;
			ftc_pkg::IDX_R_CRIT:      read_reg = s.r_crit;
			default:                  read_reg = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// Next state

	logic       addr_ok;
	logic       sel;
	logic       take;
	logic [5:0] idx;
	logic [7:0] status_view;

	always_comb begin
		st_nxt = st_r;
		idx = haddr[7:ftc_pkg::ADDR_LSB];
		addr_ok = (hsize == ftc_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0);
		sel = hsel && htrans[1] && hready;
		// Status reads hide bits whose clear is still in flight
		status_view = irq_status & ~st_r.clr_mask;
		// Zero wait states, always OKAY
		st_nxt.hready = 1'b1;
		st_nxt.hresp = 1'b0;
		st_nxt.clr_mask = 8'h00;
		st_nxt.set_ev = 8'h00;

		// Write data phase lands first so a following read sees it
		if (st_r.wr_pend) begin
			unique case (st_r.wr_idx)
				ftc_pkg::IDX_CONFIG_ONE:  st_nxt.cfg = hwdata[7:0];
				ftc_pkg::IDX_IRQ_CLEAR:   st_nxt.clr_mask = hwdata[7:0];
				ftc_pkg::IDX_IRQ_ENABLE:  st_nxt.irq_en = hwdata[7:0];
				ftc_pkg::IDX_FAN_SPEED:   st_nxt.fan_speed = hwdata[7:0];
				ftc_pkg::IDX_LOCAL_OFS:   st_nxt.local_ofs = hwdata[7:0];
				ftc_pkg::IDX_REMOTE_OFS:  st_nxt.remote_ofs = hwdata[7:0];
				ftc_pkg::IDX_TACH_LIMIT:  st_nxt.tach_lim = hwdata[7:0];
				ftc_pkg::IDX_L_HIGH:      st_nxt.l_high = hwdata[7:0];
				ftc_pkg::IDX_L_LOW:       st_nxt.l_low = hwdata[7:0];
				ftc_pkg::IDX_L_CRIT:      st_nxt.l_crit = hwdata[7:0];
				ftc_pkg::IDX_R_HIGH:      st_nxt.r_high = hwdata[7:0];
				ftc_pkg::IDX_R_LOW:       st_nxt.r_low = hwdata[7:0];
				ftc_pkg::IDX_R_CRIT:      st_nxt.r_crit = hwdata[7:0];
				default:                  st_nxt.cfg = st_nxt.cfg;
			endcase
		end

		// Address phase
		st_nxt.wr_pend = sel && hwrite && addr_ok;
		st_nxt.wr_idx = idx;
		if (sel && !hwrite) begin
			st_nxt.hrdata = 32'h0000_0000;
			if (addr_ok)
				st_nxt.hrdata[7:0] = read_reg(st_nxt, idx, status_view);
			if (addr_ok && idx == ftc_pkg::IDX_IRQ_STATUS)
				st_nxt.clr_mask = st_nxt.clr_mask | status_view;
		end

		take = meas_valid && st_r.cfg[ftc_pkg::CFG_MONITOR];
		st_nxt.meas_take = take;
		st_nxt.tach_fail = 1'b0;
		if (take) begin
			st_nxt.fan_speed = meas_tach_count;
			st_nxt.local_t = meas_local_temp;
			st_nxt.remote_t = meas_remote_temp;
			st_nxt.extra_res = meas_extra_res;
			st_nxt.tach_fail = tach_over(meas_tach_count, st_r.tach_lim);
			st_nxt.set_ev[ftc_pkg::ST_TACH] = tach_over(meas_tach_count, st_r.tach_lim);
			st_nxt.set_ev[ftc_pkg::ST_L_HIGH] = temp_above(meas_local_temp, st_r.l_high);
			st_nxt.set_ev[ftc_pkg::ST_L_LOW] = temp_above(st_r.l_low, meas_local_temp);
			st_nxt.set_ev[ftc_pkg::ST_R_HIGH] = temp_above(meas_remote_temp, st_r.r_high);
			st_nxt.set_ev[ftc_pkg::ST_R_LOW] = temp_above(st_r.r_low, meas_remote_temp);
			st_nxt.local_crit = temp_above(meas_local_temp, st_r.l_crit);
			st_nxt.remote_crit = temp_above(meas_remote_temp, st_r.r_crit);
			// Critical events fire on entry only, so a hot part does not flood status
			st_nxt.set_ev[ftc_pkg::ST_L_CRIT] = st_nxt.local_crit && !st_r.local_crit;
			st_nxt.set_ev[ftc_pkg::ST_R_CRIT] = st_nxt.remote_crit && !st_r.remote_crit;
		end

		st_nxt.fault_prev = fan_fault;
		st_nxt.set_ev[ftc_pkg::ST_FAULT_PIN] = fan_fault && !st_r.fault_prev;

		st_nxt.fault_oe = fan_fault && st_r.cfg[ftc_pkg::CFG_FAULT_EN];
		// Open drain: the pin is only ever pulled low, never driven high
		st_nxt.fault_o = 1'b0;
		st_nxt.int_n = !(st_r.cfg[ftc_pkg::CFG_INT_EN] && irq_level);
		st_nxt.pwm_out = st_r.cfg[ftc_pkg::CFG_INVERT] ? pwm_demand : !pwm_demand;
		st_nxt.rpm_target = !st_r.cfg[ftc_pkg::CFG_AUTO]
			&& (st_r.cfg[ftc_pkg::CFG_SRC_HI:ftc_pkg::CFG_SRC_LO] == ftc_pkg::SRC_FASTEST);
	end

	////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
			st_r.cfg <= ftc_pkg::CFG_RST;
			st_r.tach_lim <= ftc_pkg::TACH_LIMIT_RST;
			st_r.l_high <= ftc_pkg::L_HIGH_RST;
			st_r.l_low <= ftc_pkg::L_LOW_RST;
			st_r.l_crit <= ftc_pkg::L_CRIT_RST;
			st_r.r_high <= ftc_pkg::R_HIGH_RST;
			st_r.r_low <= ftc_pkg::R_LOW_RST;
			st_r.r_crit <= ftc_pkg::R_CRIT_RST;
			st_r.local_ofs <= ftc_pkg::OFS_RST;
			st_r.remote_ofs <= ftc_pkg::OFS_RST;
			st_r.irq_en <= ftc_pkg::IRQ_EN_RST;
			st_r.fan_speed <= ftc_pkg::VALUE_RST;
			st_r.hready <= 1'b1;
			st_r.int_n <= 1'b1;
			st_r.pwm_out <= 1'b1;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Fan failure counter and interrupt status

	ftc_fault_count #(
		.COUNT     (FAULT_COUNT)
	) u_fault (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.meas_take (st_r.meas_take),
		.tach_fail (st_r.tach_fail),
		.fault     (fan_fault)
	);

	ftc_irq_status #(
		.W       (ftc_pkg::ST_W)
	) u_irq (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.set     (st_r.set_ev),
		.clr     (st_r.clr_mask),
		.en      (st_r.irq_en),
		.status  (irq_status),
		.irq     (irq_level)
	);

	////////////////////////////////////////////////////////////////
	// Outputs

	assign hrdata = st_r.hrdata;
	assign hreadyout = st_r.hready;
	assign hresp = st_r.hresp;
	assign monitor_en = st_r.cfg[ftc_pkg::CFG_MONITOR];
	assign speed_sense_select = st_r.cfg[ftc_pkg::CFG_SENSE];
	assign auto_or_software_select = st_r.cfg[ftc_pkg::CFG_AUTO];
	assign auto_source = st_r.cfg[ftc_pkg::CFG_SRC_HI:ftc_pkg::CFG_SRC_LO];
	assign sw_target_is_rpm = st_r.rpm_target;
	assign local_offset = st_r.local_ofs;
	assign remote_offset = st_r.remote_ofs;
	assign local_crit = st_r.local_crit;
	assign remote_crit = st_r.remote_crit;
	assign pwm_out = st_r.pwm_out;
	assign int_n = st_r.int_n;
	assign fan_fault_n_o = st_r.fault_o;
	assign fan_fault_n_oe = st_r.fault_oe;
	assign irq = irq_level;

endmodule

// ---- tb/ftc_regs_checker.sv ----
/*
 * Port checker for the fan and thermal register bank.
 * Assumes ce high and hready fed from hreadyout.
 */
`timescale 1ns/1ns
module ftc_regs_checker (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Configuration and pins
	input wire logic        monitor_en,
	input wire logic        auto_or_software_select,
	input wire logic [1:0]  auto_source,
	input wire logic        sw_target_is_rpm,
	input wire logic        int_n,
	input wire logic        irq,
	input wire logic        fan_fault_n_o
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////
	zero_wait_a: assert property (hreadyout && !hresp)
		else $error("slave stalled or answered with error");
	read_upper_a: assert property (hrdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	mon_write_a: assert property ($changed(monitor_en) |-> $past(hsel && htrans[1] && hwrite, 2))
		else $error("monitor enable moved without a write");
	auto_write_a: assert property ($changed({auto_or_software_select, auto_source})
		|-> $past(hsel && htrans[1] && hwrite, 2)) else $error("control mode moved without a write");
	rpm_mode_a: assert property (sw_target_is_rpm ==
		($past(!auto_or_software_select) && $past(auto_source) == 2'h3)) else $error("rpm target wrong");
	int_cause_a: assert property (!int_n |-> $past(irq))
		else $error("int_n low without irq");
	int_release_a: assert property (!irq |=> int_n)
		else $error("int_n held after irq dropped");
	fault_drive_a: assert property (fan_fault_n_o == 1'h0)
		else $error("fan fault pin driven high");
endmodule

bind ftc_regs_top ftc_regs_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .monitor_en(monitor_en),
	.auto_or_software_select(auto_or_software_select), .auto_source(auto_source),
	.sw_target_is_rpm(sw_target_is_rpm), .int_n(int_n), .irq(irq), .fan_fault_n_o(fan_fault_n_o));

// ---- tb/ftc_host_model.sv ----
/*
 * Host processor model: single-word AHB-Lite master.
 * Assumes one slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ns
module ftc_host_model (
	// Clock
	input wire logic        hclk,
	// Slave answer
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	// Request
	output logic            hsel,
	output logic [31:0]     haddr,
	output logic [1:0]      htrans,
	output logic            hwrite,
	output logic [2:0]      hsize,
	output logic [31:0]     hwdata
);
	int tmo = 0;
	initial begin
		hsel = 1'h0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = ftc_pkg::HSIZE_WORD;
		hwdata = 32'h00000000;
	end
	// Bounded wait for hready at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1 && n < 16) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 16)
			tmo++;
	endtask
	task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
		hsel   <= 1'h1;
		haddr  <= {24'h000000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_ready();
		hsel   <= 1'h0;
		htrans <= 2'h0;
		// Read phases carry a changing pattern, not stale data
		hwdata <= wr ? {24'h000000, wd} : ~hwdata;
		wait_ready();
		rd = hrdata[7:0];
	endtask
endmodule

// ---- tb/ftc_regs_top_tb.sv ----
/*
 * Scenario testbench for the fan and thermal register bank.
 * Assumes the host model drives the bus and the bench the measurements.
 */
`timescale 1ns/1ns
module ftc_regs_top_tb;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        ce = 1'h1;
	logic        meas_valid = 1'h0;
	logic [7:0]  meas_tach_count = 8'h00;
	logic [7:0]  meas_local_temp = 8'h00;
	logic [7:0]  meas_remote_temp = 8'h00;
	logic [7:0]  meas_extra_res = 8'h00;
	logic        pwm_demand = 1'h1;
	logic        hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans, auto_source;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0]  local_offset, remote_offset;
	logic        monitor_en, speed_sense_select, auto_or_software_select, sw_target_is_rpm;
	logic        local_crit, remote_crit, pwm_out, int_n, fan_fault_n_o, fan_fault_n_oe, irq;
	int          num_errors = 0;
	int          n_tests = 0;
	logic [5:0]  rix [9] = '{6'h0D, 6'h0E, 6'h10, 6'h14, 6'h15, 6'h16, 6'h18, 6'h19, 6'h1A};
	logic [7:0]  rv [9] = '{8'h11, 8'h22, 8'h7F, 8'h3D, 8'h01, 8'h47, 8'h51, 8'h02, 8'h65};

	always #10 hclk = ~hclk;

	ftc_regs_top ftc_regs_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas_valid(meas_valid),
		.meas_tach_count(meas_tach_count), .meas_local_temp(meas_local_temp),
		.meas_remote_temp(meas_remote_temp), .meas_extra_res(meas_extra_res), .pwm_demand(pwm_demand),
		.monitor_en(monitor_en), .speed_sense_select(speed_sense_select),
		.auto_or_software_select(auto_or_software_select), .auto_source(auto_source),
		.sw_target_is_rpm(sw_target_is_rpm), .local_offset(local_offset), .remote_offset(remote_offset),
		.local_crit(local_crit), .remote_crit(remote_crit), .pwm_out(pwm_out), .int_n(int_n),
		.fan_fault_n_o(fan_fault_n_o), .fan_fault_n_oe(fan_fault_n_oe), .irq(irq));
	ftc_host_model ftc_host_model_i (.hclk(hclk), .hrdata(hrdata), .hreadyout(hreadyout), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] x;
		ftc_host_model_i.xfer(idx, 1'h1, d, x);
	endtask
	task automatic rdchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		ftc_host_model_i.xfer(idx, 1'h0, 8'h00, x);
		chk(what, {24'h000000, x}, {24'h000000, exp});
	endtask
	// One measurement set, then enough cycles for status, int_n and fault pin
	task automatic meas(input logic [7:0] t);
		meas_tach_count  <= t;
		meas_local_temp  <= 8'h20;
		meas_remote_temp <= 8'h30;
		meas_extra_res   <= 8'h10;
		meas_valid       <= 1'h1;
		@(posedge hclk);
		meas_valid <= 1'h0;
		repeat (5) @(posedge hclk);
	endtask
	task automatic t_reset();
		logic [5:0] ix [16] = '{6'h00, 6'h10, 6'h14, 6'h15, 6'h16, 6'h18, 6'h19, 6'h1A,
			6'h0D, 6'h0E, 6'h08, 6'h0A, 6'h0B, 6'h06, ftc_pkg::IDX_IRQ_STATUS, ftc_pkg::IDX_IRQ_ENABLE};
		logic [7:0] ev [16] = '{8'h90, 8'hFF, 8'h3C, 8'h00, 8'h46, 8'h50, 8'h00, 8'h64,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 16; i++)
			rdchk("reset value", ix[i], ev[i]);
		chk("monitor_en", monitor_en, 1'h0);
		chk("int_n", int_n, 1'h1);
		chk("sense", speed_sense_select, 1'h0);
		chk("pwm_out", pwm_out, 1'h0);
		chk("fault oe", fan_fault_n_oe, 1'h0);
		chk("auto", auto_or_software_select, 1'h1);
		$display("t_reset done");
	endtask
	task automatic t_rw();
		logic [5:0] ro [4] = '{6'h06, 6'h0A, 6'h0B, 6'h3F};
		for (int i = 0; i < 9; i++)
			wr(rix[i], rv[i]);
		for (int i = 0; i < 9; i++)
			rdchk("rw reg", rix[i], rv[i]);
		chk("local offset", local_offset, 8'h11);
		chk("remote offset", remote_offset, 8'h22);
		for (int i = 0; i < 4; i++) begin
			wr(ro[i], 8'hFF);
			rdchk("read only", ro[i], 8'h00);
		end
		$display("t_rw done");
	endtask
	task automatic t_cfg();
		logic [7:0] cv [4] = '{8'h0C, 8'h61, 8'hE2, 8'h00};
		for (int i = 0; i < 4; i++) begin
			pwm_demand <= i[0];
			wr(6'h00, cv[i]);
			repeat (2) @(posedge hclk);
			rdchk("config", 6'h00, cv[i]);
			chk("monitor_en", monitor_en, cv[i][0]);
			chk("sense", speed_sense_select, cv[i][2]);
			chk("pwm_out", pwm_out, cv[i][3] ? i[0] : !i[0]);
			chk("source", auto_source, cv[i][6:5]);
			chk("rpm", sw_target_is_rpm, !cv[i][7] && cv[i][6:5] == 2'h3);
			chk("auto", auto_or_software_select, cv[i][7]);
		end
		$display("t_cfg done");
	endtask
	task automatic t_meas();
		meas(8'h40);
		rdchk("held speed", 6'h08, 8'h00);
		wr(6'h00, 8'h13);
		meas(8'h7F);
		rdchk("speed", 6'h08, 8'h7F);
		rdchk("local", 6'h0A, 8'h20);
		rdchk("remote", 6'h0B, 8'h30);
		rdchk("extra", 6'h06, 8'h10);
		rdchk("equal limit", ftc_pkg::IDX_IRQ_STATUS, 8'h00);
		$display("t_meas done");
	endtask
	task automatic t_irq();
		wr(ftc_pkg::IDX_IRQ_ENABLE, 8'h01);
		meas(8'h80);
		chk("irq", irq, 1'h1);
		chk("int_n", int_n, 1'h0);
		rdchk("status", ftc_pkg::IDX_IRQ_STATUS, 8'h01);
		repeat (3) @(posedge hclk);
		chk("irq read", irq, 1'h0);
		chk("int_n read", int_n, 1'h1);
		wr(ftc_pkg::IDX_IRQ_ENABLE, 8'h00);
		meas(8'h80);
		chk("masked irq", irq, 1'h0);
		wr(ftc_pkg::IDX_IRQ_CLEAR, 8'h01);
		rdchk("cleared", ftc_pkg::IDX_IRQ_STATUS, 8'h00);
		wr(ftc_pkg::IDX_IRQ_ENABLE, 8'h01);
		wr(6'h00, 8'h11);
		meas(8'h80);
		chk("irq", irq, 1'h1);
		chk("int_n off", int_n, 1'h1);
		$display("t_irq done");
	endtask
	task automatic t_fault();
		wr(6'h00, 8'h13);
		meas(8'h7F);
		for (int i = 0; i < 4; i++)
			meas(8'hFF);
		chk("fault four", fan_fault_n_oe, 1'h0);
		meas(8'hFF);
		chk("fault five", fan_fault_n_oe, 1'h1);
		wr(6'h00, 8'h03);
		repeat (2) @(posedge hclk);
		chk("fault off", fan_fault_n_oe, 1'h0);
		wr(6'h00, 8'h13);
		repeat (2) @(posedge hclk);
		chk("fault on", fan_fault_n_oe, 1'h1);
		meas(8'h10);
		chk("recovered", fan_fault_n_oe, 1'h0);
		$display("t_fault done");
	endtask
	task automatic t_temp();
		logic [7:0] lt [2] = '{8'h48, 8'hF0};
		logic [7:0] rt [2] = '{8'h66, 8'hFF};
		logic [7:0] se [2] = '{8'h6A, 8'h14};
		wr(ftc_pkg::IDX_IRQ_CLEAR, 8'hFF);
		@(posedge hclk);
		for (int i = 0; i < 2; i++) begin
			meas_tach_count  <= 8'h10;
			meas_local_temp  <= lt[i];
			meas_remote_temp <= rt[i];
			meas_valid       <= 1'h1;
			@(posedge hclk);
			meas_valid <= 1'h0;
			repeat (3) @(posedge hclk);
			chk("local crit", local_crit, !i[0]);
			chk("remote crit", remote_crit, !i[0]);
			rdchk("temp status", ftc_pkg::IDX_IRQ_STATUS, se[i]);
		end
		$display("t_temp done");
	endtask
	task automatic t_ce();
		ce <= 1'h0;
		meas(8'h55);
		ce <= 1'h1;
		rdchk("frozen speed", 6'h08, 8'h10);
		rdchk("frozen local", 6'h0A, 8'hF0);
		$display("t_ce done");
	endtask
	task automatic report_and_stop();
		num_errors += ftc_host_model_i.tmo;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		t_reset();
		t_rw();
		t_cfg();
		t_meas();
		t_irq();
		t_fault();
		t_temp();
		t_ce();
		report_and_stop();
	end
endmodule
